/* File: msc_decode.sv */
// combinational decode of the 4-bit monitor select code
`timescale 1ns/1ps
module msc_decode (
	msc_sel_if.dec s
);
	import msc_pkg::*;
	// low bits give the channel, top bit chooses transmitter: each code with a
	// nonzero channel is a distinct target, and both x000 codes mean no monitoring
	assign s.chan   = s.code[CW-1:0];
	assign s.active = (s.code[CW-1:0] != NO_CHAN);
	assign s.is_tx  = s.code[SEL_TX_BIT];
endmodule : msc_decode

/* File: msc_monitor_ctl.sv */
// monitor routing, driver enable and receive polarity with wishbone regs
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module msc_monitor_ctl (
	input  wire logic                       clock,
	input  wire logic                       srst,
	input  wire logic                       ce,
	// wishbone classic slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [3:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic [31:0]                     wb_dat_o,
	output logic                            wb_ack_o,
	// mode pins
	input  wire logic                       hw_mode,
	input  wire logic [msc_pkg::SELW-1:0]   monitor_target_select,
	input  wire logic                       upper_address_input,
	input  wire logic                       driver_enable,
	input  wire logic                       receive_edge_select,
	// per-channel core side, plus the single host clock
	input  wire logic [msc_pkg::NCH-1:0]    tx_tip_core,
	input  wire logic [msc_pkg::NCH-1:0]    tx_ring_core,
	input  wire logic [msc_pkg::NCH-1:0]    rx_line_tip_in,
	input  wire logic [msc_pkg::NCH-1:0]    rx_line_ring_in,
	input  wire logic [msc_pkg::NCH-1:0]    rx_pos_core,
	input  wire logic [msc_pkg::NCH-1:0]    rx_neg_core,
	input  wire logic [msc_pkg::NCH-1:0]    rx_clk_core,
	input  wire logic                       host_clock_core,
	// line and receive outputs
	output logic [msc_pkg::NCH-1:0]         tx_line_tip,
	output logic [msc_pkg::NCH-1:0]         tx_line_ring,
	output logic [msc_pkg::NCH-1:0]         tx_line_oe,
	output logic                            monitor_rx_line_tip,
	output logic                            monitor_rx_line_ring,
	output logic [msc_pkg::NCH-1:0]         rx_data_pos,
	output logic [msc_pkg::NCH-1:0]         rx_data_neg,
	output logic [msc_pkg::NCH-1:0]         rx_recovered_clock,
	output logic                            host_clock_active
);
	import msc_pkg::*;

	logic [6:0]      ctrl_r;
	logic            ack_r;
	logic [31:0]     dat_r;
	logic            addr_bad_r;
	logic [SELW-1:0] sel_eff;
	logic            loop0;
	logic            clkrec;
	logic            host;
	logic            req;
	logic            mon_tx;
	logic            mon_rx;
	logic            loop_fwd;
	logic            mon_tip;
	logic            mon_ring;
	logic            fwd_tip;
	logic            fwd_ring;
	logic [31:0]     stat_word;

	msc_sel_if s ();

	msc_decode u_dec (
		.s (s.dec)
	);

	assign loop0  = ctrl_r[CTRL_LOOP0];
	assign clkrec = ctrl_r[CTRL_CLKREC];
	assign host   = ctrl_r[CTRL_HOST] & ~hw_mode;
	// pins steer the select in hardware mode, the register under host
	assign sel_eff = hw_mode ? monitor_target_select
		: ctrl_r[CTRL_SEL_LSB +: SELW];
	assign s.code  = sel_eff;

	assign req    = wb_cyc_i & wb_stb_i;
	assign mon_tx = s.active & s.is_tx;
	assign mon_rx = s.active & ~s.is_tx;
	assign loop_fwd = host & loop0 & s.active;

	// transmit pair of the target replaces channel 0 line inputs
	assign mon_tip  = mon_tx ? tx_tip_core[s.chan]  : rx_line_tip_in[0];
	assign mon_ring = mon_tx ? tx_ring_core[s.chan] : rx_line_ring_in[0];
	// what channel 0 sends back out when remote loopback is on
	assign fwd_tip  = mon_tx ? tx_tip_core[s.chan]  : rx_line_tip_in[s.chan];
	assign fwd_ring = mon_tx ? tx_ring_core[s.chan] : rx_line_ring_in[s.chan];

	always_comb begin
		stat_word = '0;
		stat_word[STAT_SEL_LSB +: SELW] = sel_eff;
		stat_word[STAT_ACTIVE]          = s.active;
		stat_word[STAT_IS_TX]           = s.is_tx;
		stat_word[STAT_CH_LSB +: CW]    = s.chan;
		stat_word[STAT_DRV_EN]          = driver_enable;
		stat_word[STAT_EDGE]            = receive_edge_select;
		stat_word[STAT_ADDR_BAD]        = addr_bad_r;
	end

	// bus handshake: one wait state, ack dropped the cycle after
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_r <= 1'b0;
		end else if (ce) begin
			ack_r <= req & ~ack_r;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_r <= CTRL_RESET;
		end else if (ce && req && !ack_r && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == ADDR_CTRL) begin
			ctrl_r <= wb_dat_i[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			dat_r <= 32'h0000_0000;
		end else if (ce && req && !ack_r) begin
			unique case (wb_adr_i)
				ADDR_CTRL: dat_r <= {25'h0000000, ctrl_r};
				ADDR_STAT: dat_r <= stat_word;
				default:   dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// sticky flag: board broke the grounded address rule in hw mode;
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			addr_bad_r <= 1'b0;
		end else if (ce) begin
			if (hw_mode && upper_address_input) begin
				addr_bad_r <= 1'b1;
			end else if (req && !ack_r && wb_we_i && wb_sel_i[1]
				&& wb_adr_i == ADDR_STAT
				&& wb_dat_i[STAT_ADDR_BAD]) begin
				addr_bad_r <= 1'b0;
			end
		end
	end

	// channel 0 receive inputs, swapped to the monitored transmitter
	always_ff @(posedge clock) begin
		if (srst) begin
			monitor_rx_line_tip  <= 1'b0;
			monitor_rx_line_ring <= 1'b0;
		end else if (ce) begin
			monitor_rx_line_tip  <= mon_tip;
			monitor_rx_line_ring <= mon_ring;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			host_clock_active <= 1'b0;
		end else if (ce) begin
			host_clock_active <= host_clock_core ^ ~receive_edge_select;
		end
	end

	// driver enable only floats pins; data paths keep toggling so a
	// standby unit can take over without relays
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic src_pos;
			logic src_neg;
			logic src_tip;
			logic src_ring;
			if (g == 0) begin : g_mon
				assign src_pos  = mon_rx ? rx_pos_core[s.chan] : rx_pos_core[0];
				assign src_neg  = mon_rx ? rx_neg_core[s.chan] : rx_neg_core[0];
				assign src_tip  = loop_fwd ? fwd_tip  : tx_tip_core[0];
				assign src_ring = loop_fwd ? fwd_ring : tx_ring_core[0];
			end else begin : g_norm
				assign src_pos  = rx_pos_core[g];
				assign src_neg  = rx_neg_core[g];
				assign src_tip  = tx_tip_core[g];
				assign src_ring = tx_ring_core[g];
			end

			always_ff @(posedge clock) begin
				if (srst) begin
					tx_line_tip[g]  <= 1'b0;
					tx_line_ring[g] <= 1'b0;
					tx_line_oe[g]   <= 1'b0;
				end else if (ce) begin
					tx_line_tip[g]  <= src_tip;
					tx_line_ring[g] <= src_ring;
					tx_line_oe[g]   <= driver_enable;
				end
			end

			// edge select high: rising clock edge and active-high data
			always_ff @(posedge clock) begin
				if (srst) begin
					rx_data_pos[g]        <= 1'b0;
					rx_data_neg[g]        <= 1'b0;
					rx_recovered_clock[g] <= 1'b0;
				end else if (ce) begin
					rx_recovered_clock[g] <= rx_clk_core[g]
						^ ~receive_edge_select;
					if (clkrec) begin
						rx_data_pos[g] <= src_pos;
						rx_data_neg[g] <= src_neg;
					end else begin
						rx_data_pos[g] <= src_pos ^ ~receive_edge_select;
						rx_data_neg[g] <= src_neg ^ ~receive_edge_select;
					end
				end
			end
		end
	endgenerate

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
endmodule : msc_monitor_ctl

/* File: msc_monitor_ctl_props.sv */
// assertions on the monitor control ports
`timescale 1ns/1ps
module msc_monitor_ctl_props (
	input wire logic       clock, srst, wb_cyc_i, wb_stb_i, wb_ack_o,
	input wire logic       hw_mode, driver_enable, receive_edge_select,
	input wire logic       monitor_rx_line_tip,
	input wire logic [3:0] monitor_target_select,
	input wire logic [7:0] tx_tip_core, rx_line_tip_in, rx_pos_core,
	input wire logic [7:0] rx_clk_core, tx_line_oe, tx_line_tip,
	input wire logic [7:0] rx_data_pos, rx_recovered_clock
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire logic [2:0] ch = monitor_target_select[2:0];
	wire logic       tx = monitor_target_select[3];
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	a_ack_once: assert property (s_req |=> s_ack) else $error("ack");
	a_drv_off: assert property (!driver_enable |=> tx_line_oe == 8'h00)
		else $error("float");
	a_drv_on: assert property (driver_enable |=> tx_line_oe == 8'hff)
		else $error("drive");
	a_keep_run: assert property (hw_mode && !driver_enable |=>
		tx_line_tip == $past(tx_tip_core)) else $error("tx stop");
	a_tx_mon: assert property (hw_mode && tx && ch != 0 |=>
		monitor_rx_line_tip == $past(tx_tip_core[ch])) else $error("tx mon");
	a_rx_mon: assert property (hw_mode && !tx && ch != 0 &&
		receive_edge_select |=> rx_data_pos[0] == $past(rx_pos_core[ch]))
		else $error("rx mon");
	a_no_mon: assert property (hw_mode && ch == 0 |=>
		monitor_rx_line_tip == $past(rx_line_tip_in[0])) else $error("mon");
	a_clk_edge: assert property (1 |=> rx_recovered_clock ==
		($past(rx_clk_core) ^ {8{!$past(receive_edge_select)}}))
		else $error("edge");
endmodule : msc_monitor_ctl_props
bind msc_monitor_ctl msc_monitor_ctl_props u_props (.clock, .srst, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .hw_mode, .driver_enable, .receive_edge_select,
	.monitor_rx_line_tip, .monitor_target_select, .tx_tip_core,
	.rx_line_tip_in, .rx_pos_core, .rx_clk_core, .tx_line_oe, .tx_line_tip,
	.rx_data_pos, .rx_recovered_clock);

/* File: msc_monitor_ctl_test.sv */
// bench for the monitor control block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module msc_monitor_ctl_test;
	import msc_pkg::*;
	typedef struct {int k; logic [31:0] v, m;} msc_exp_t;
	msc_exp_t q[$], e;
	int errors = 0, num_checks = 0, cyc_n = 0;
	logic clock = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic hold = 0, host_clock_core = 0, w_hw = 1, w_drv = 1, w_edge = 1;
	logic [3:0] wb_adr_i = 0, w_sel = 0;
	logic [31:0] wb_dat_i = 0;
	logic [7:0] tx_tip_core = 0, tx_ring_core = 0, rx_line_tip_in = 0;
	logic [7:0] rx_line_ring_in = 0, rx_pos_core = 0, rx_neg_core = 0;
	logic [7:0] rx_clk_core = 0;
	wire logic hw_mode, upper_address_input, driver_enable, wb_ack_o;
	wire logic receive_edge_select;
	wire logic [3:0] monitor_target_select;
	wire logic [31:0] wb_dat_o;
	wire logic [7:0] tx_line_tip, rx_data_pos;
	msc_monitor_ctl dut (.clock, .srst, .ce(1'b1), .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.hw_mode, .monitor_target_select, .upper_address_input, .driver_enable,
		.receive_edge_select, .tx_tip_core, .tx_ring_core, .rx_line_tip_in,
		.rx_line_ring_in, .rx_pos_core, .rx_neg_core, .rx_clk_core,
		.host_clock_core, .tx_line_tip, .tx_line_ring(), .tx_line_oe(),
		.monitor_rx_line_tip(), .monitor_rx_line_ring(), .rx_data_pos,
		.rx_data_neg(), .rx_recovered_clock(), .host_clock_active());
	msc_strap_model pm (.clock, .want_hw(w_hw), .want_sel(w_sel),
		.want_drv(w_drv), .want_edge(w_edge), .hw_mode, .monitor_target_select,
		.upper_address_input, .driver_enable, .receive_edge_select);
	always #4 clock = ~clock;
	always @(posedge clock) if (!hold) begin
		{tx_tip_core, tx_ring_core, rx_line_tip_in, rx_line_ring_in, rx_pos_core,
			rx_neg_core, rx_clk_core} <= {$urandom, 24'($urandom)};
		host_clock_core <= 1'($urandom);
	end
	// kind 0 waits for ack, others compare against held core inputs
	always @(posedge clock) if (q.size() > 0 && (wb_ack_o || q[0].k > 0)) begin
		e = q.pop_front();
		`CHK((e.k == 0 ? wb_dat_o : e.k == 1 ? {24'h0, rx_data_pos} :
			{24'h0, tx_line_tip}) & e.m, e.v & e.m)
	end
	always @(posedge clock) if (++cyc_n > 20000) begin
		errors++;
		end_of_test();
	end
	task automatic end_of_test();
		if (q.size() > 0) errors++;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clock);
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [31:0] v, m);
		q.push_back('{0, v, m});
		wb(0, a, 0);
	endtask : rd
	initial begin
		void'($urandom(60571));
		repeat (12) @(posedge clock);
		srst <= 0;
		@(posedge clock);
		rd(ADDR_CTRL, 32'h20, '1);
		wb(1, 4'h8, 32'hff);
		rd(4'h8, 0, '1);
		rd(ADDR_CTRL, 32'h20, '1);
		for (int i = 0; i < 16; i++) begin
			w_sel <= 4'(i);
			w_drv <= 1'($urandom);
			w_edge <= 1'($urandom);
			repeat (3) @(posedge clock);
			rd(ADDR_STAT, {20'h0, 1'b0, w_edge, w_drv, 3'(i), i[3],
				1'(i % 8 != 0), 4'(i)}, i % 8 ? '1 : 32'hffffffdf);
		end
		// data held still so one sample is a fair expectation
		hold <= 1;
		w_sel <= 0;
		w_drv <= 1;
		for (int i = 0; i < 4; i++) begin
			wb(1, ADDR_CTRL, {26'h0, i[1], 5'h0});
			w_edge <= i[0];
			repeat (3) @(posedge clock);
			q.push_back('{1, {24'h0, rx_pos_core ^ {8{!i[0] && !i[1]}}}, 'hff});
		end
		w_hw <= 0;
		wb(1, ADDR_CTRL, 32'h7b);
		repeat (3) @(posedge clock);
		q.push_back('{2, {31'h0, tx_tip_core[3]}, 32'h1});
		repeat (4) @(posedge clock);
		end_of_test();
	end
endmodule : msc_monitor_ctl_test

/* File: msc_pkg.sv */
// constants for the monitor select and line driver control block
package msc_pkg;
	localparam int unsigned NCH        = 8;
	localparam int unsigned CW         = 3;
	localparam int unsigned SELW       = 4;
	// register byte offsets
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STAT   = 4'h4;
	// control register fields
	localparam int unsigned CTRL_SEL_LSB  = 0;
	localparam int unsigned CTRL_LOOP0    = 4;
	localparam int unsigned CTRL_CLKREC   = 5;
	localparam int unsigned CTRL_HOST     = 6;
	localparam logic [6:0]  CTRL_RESET    = 7'h20;
	// status register fields
	localparam int unsigned STAT_SEL_LSB  = 0;
	localparam int unsigned STAT_ACTIVE   = 4;
	localparam int unsigned STAT_IS_TX    = 5;
	localparam int unsigned STAT_CH_LSB   = 6;
	localparam int unsigned STAT_DRV_EN   = 9;
	localparam int unsigned STAT_EDGE     = 10;
	localparam int unsigned STAT_ADDR_BAD = 11;
	// select code bit that chooses transmitter over receiver
	localparam int unsigned SEL_TX_BIT    = 3;
	localparam logic [CW-1:0] NO_CHAN     = 3'h0;
endpackage : msc_pkg

/* File: msc_sel_if.sv */
// decoded monitoring target passed between decoder and control
`timescale 1ns/1ps
interface msc_sel_if;
	import msc_pkg::*;
	logic [SELW-1:0] code;
	logic            active;
	logic            is_tx;
	logic [CW-1:0]   chan;
	modport dec (input code, output active, is_tx, chan);
	modport ctl (output code, input active, is_tx, chan);
endinterface : msc_sel_if

/* File: msc_strap_model.sv */
// strap model driving the hardware mode pins
`timescale 1ns/1ps
module msc_strap_model (
	input  wire logic       clock,
	input  wire logic       want_hw,
	input  wire logic [3:0] want_sel,
	input  wire logic       want_drv,
	input  wire logic       want_edge,
	output logic            hw_mode,
	output logic [3:0]      monitor_target_select,
	output logic            upper_address_input,
	output logic            driver_enable,
	output logic            receive_edge_select
);
	always_ff @(posedge clock) begin
		hw_mode <= want_hw;
		monitor_target_select <= want_sel;
		upper_address_input <= 1'b0;
		driver_enable <= want_drv;
		receive_edge_select <= want_edge;
	end
endmodule : msc_strap_model
